/* design/trc_regs.vh */
`ifndef TRC_REGS_VH
`define TRC_REGS_VH
// ***********************************************
// Register offsets
// ***********************************************
`define TRC_OFS_CTRL      12'h000
`define TRC_OFS_STATUS    12'h004
`define TRC_OFS_IRQ_STAT  12'h008
`define TRC_OFS_IRQ_MASK  12'h00C
`define TRC_OFS_FUNC      12'h010
`define TRC_OFS_DELAY     12'h014
// ***********************************************
// Field positions
// ***********************************************
`define TRC_CTRL_RUN      0
`define TRC_CTRL_REMOTE   1
`define TRC_CTRL_RS_NC    2
`define TRC_IRQ_TRIP      0
`define TRC_IRQ_RESET     1
`define TRC_IRQ_LINKERR   2
`define TRC_IRQ_OTEMP     3
// ***********************************************
// Values
// ***********************************************
`define TRC_FUNC_RESET    8'h12
`define TRC_FUNC_OTEMP    8'h13
`define TRC_OTEMP_CODE    8'h23
`define TRC_FUNC_RST_VAL  8'h00
`define TRC_CTRL_RST_VAL  3'h0
// ***********************************************
// Timing
// ***********************************************
`define TRC_CLK_HZ        20000000
`define TRC_MS_CYC        (`TRC_CLK_HZ / 1000)
`define TRC_ALARM_MS      30
`define TRC_LINKERR_MS    4000
`define TRC_HOLD_MS       1000
`define TRC_KEY_WIN_MS    3000
`endif

/* design/trc_sync.v */
`default_nettype none
// ***********************************************
// Two-stage synchroniser, one per bit
// ***********************************************
module trc_sync #(
   parameter W = 8
) (
   input  wire         hclk,
   input  wire         hresetn,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               s1_q[i] <= 1'b0;
               s2_q[i] <= 1'b0;
            end else begin
               s1_q[i] <= d[i];
               s2_q[i] <= s1_q[i];
            end
         end
      end
   endgenerate
   assign q = s2_q;
endmodule
`default_nettype wire

/* design/trc_top.v */
`default_nettype none
`include "trc_regs.vh"
module trc_top #(
   parameter        NIN          = 5,
   parameter        NOUT         = 3,
   parameter [31:0] MS_CYC       = `TRC_MS_CYC,
   parameter [15:0] LINKERR_MS   = `TRC_LINKERR_MS,
   parameter [15:0] HOLD_MS      = `TRC_HOLD_MS,
   parameter [15:0] KEY_WIN_MS   = `TRC_KEY_WIN_MS
) (
   input  wire            hclk,
   input  wire            hresetn,
   input  wire            hsel,
   input  wire [31:0]     haddr,
   input  wire [1:0]      htrans,
   input  wire            hwrite,
   input  wire [2:0]      hsize,
   input  wire [31:0]     hwdata,
   input  wire            hready,
   output reg  [31:0]     hrdata,
   output reg             hreadyout,
   output reg             hresp,
   input  wire [NIN-1:0]  term_in,
   input  wire            overtemp_open_in,
   input  wire            key_stop_reset,
   input  wire            key_any,
   input  wire [NOUT-1:0] logic_out_req,
   output reg             motor_drive,
   output reg  [NOUT-1:0] logic_out,
   output reg             alarm_out,
   output reg  [7:0]      trip_code,
   output reg             remote_link_error_message,
   output reg             irq
);
   localparam ST_POR  = 3'b001;
   localparam ST_RUN  = 3'b010;
   localparam ST_TRIP = 3'b100;
   localparam WSY     = NIN + 3;
   // ***********************************************
   // Input synchronisation
   // ***********************************************
   wire [WSY-1:0] sy;
   trc_sync #(.W(WSY)) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       ({key_any, key_stop_reset, overtemp_open_in, term_in}),
      .q       (sy)
   );
   wire [NIN-1:0] term_s = sy[NIN-1:0];
   wire           open_s = sy[NIN];
   wire           key_s  = sy[NIN+1];
   wire           anyk_s = sy[NIN+2];
   // ***********************************************
   // Registers
   // ***********************************************
   reg  [2:0]         ctrl_q;
   reg  [8*NIN-1:0]   func_q;
   reg  [NOUT-1:0]    delay_en_q;
   reg  [3:0]         istat_q;
   reg  [3:0]         imask_q;
   reg  [2:0]         state_q;
   reg  [31:0]        tick_cnt_q;
   reg                tick_q;
   reg                rs_prev_q;
   reg                key_prev_q;
   reg  [15:0]        hold_cnt_q;
   reg  [15:0]        up_cnt_q;
   reg                por_rs_q;
   reg  [15:0]        lerr_cnt_q;
   reg                ot_trip_q;
   reg                ap_valid_q;
   reg                ap_write_q;
   reg  [11:0]        ap_addr_q;
   // ***********************************************
   // Terminal function decode
   // ***********************************************
   reg rs_s;
   reg th_s;
   integer k;
   always @* begin
      rs_s = 1'b0;
      th_s = 1'b0;
      for (k = 0; k < NIN; k = k + 1) begin
         if (func_q[8*k +: 8] == `TRC_FUNC_RESET && !ctrl_q[`TRC_CTRL_RS_NC]) begin
            rs_s = rs_s | term_s[k];
         end
      end
      if (func_q[8*(NIN-1) +: 8] == `TRC_FUNC_OTEMP) begin
         th_s = term_s[NIN-1];
      end
   end
   wire ot_now   = th_s | (open_s & (func_q[8*(NIN-1) +: 8] == `TRC_FUNC_OTEMP));
   wire rs_rise  = rs_s & ~rs_prev_q;
   wire rs_fall  = ~rs_s & rs_prev_q;
   wire key_rise = key_s & ~key_prev_q;
   wire key_ok   = key_rise & (~ctrl_q[`TRC_CTRL_REMOTE] | (up_cnt_q < KEY_WIN_MS));
   wire alarm    = (state_q == ST_TRIP);
   wire key_rst  = key_ok & alarm & ~(ot_trip_q & ot_now);
   wire do_rst   = rs_fall | key_rst;
   // ***********************************************
   // Millisecond tick
   // ***********************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt_q <= 32'h00000000;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q == MS_CYC - 32'h00000001) begin
         tick_cnt_q <= 32'h00000000;
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h00000001;
         tick_q     <= 1'b0;
      end
   end
   // ***********************************************
   // Trip state machine
   // ***********************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q    <= ST_POR;
         rs_prev_q  <= 1'b0;
         key_prev_q <= 1'b0;
         ot_trip_q  <= 1'b0;
      end else begin
         rs_prev_q  <= rs_s;
         key_prev_q <= key_s;
         case (state_q)
            ST_POR: begin
               if (!rs_s) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (rs_s) begin
                  state_q <= ST_POR;
               end else if (ot_now) begin
                  state_q   <= ST_TRIP;
                  ot_trip_q <= 1'b1;
               end
            end
            ST_TRIP: begin
               if (rs_s) begin
                  state_q   <= ST_POR;
                  ot_trip_q <= 1'b0;
               end else if (do_rst) begin
                  state_q   <= ST_RUN;
                  ot_trip_q <= 1'b0;
               end
            end
            default: begin
               state_q <= ST_POR;
            end
         endcase
      end
   end
   // ***********************************************
   // Power-up timing and link error
   // ***********************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         up_cnt_q   <= 16'h0000;
         por_rs_q   <= 1'b1;
         lerr_cnt_q <= 16'h0000;
         remote_link_error_message <= 1'b0;
      end else begin
         if (tick_q && up_cnt_q != 16'hFFFF) begin
            up_cnt_q <= up_cnt_q + 16'h0001;
         end
         if (!rs_s) begin
            por_rs_q <= 1'b0;
         end
         if (por_rs_q && rs_s && tick_q && lerr_cnt_q != 16'hFFFF) begin
            lerr_cnt_q <= lerr_cnt_q + 16'h0001;
         end
         if (por_rs_q && rs_s && lerr_cnt_q >= LINKERR_MS) begin
            remote_link_error_message <= 1'b1;
         end else if (!rs_s && anyk_s) begin
            remote_link_error_message <= 1'b0;
         end
      end
   end
   // ***********************************************
   // Outputs and off-delay
   // ***********************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_cnt_q  <= 16'h0000;
         motor_drive <= 1'b0;
         logic_out   <= {NOUT{1'b0}};
         alarm_out   <= 1'b0;
         trip_code   <= 8'h00;
      end else begin
         motor_drive <= ctrl_q[`TRC_CTRL_RUN] & (state_q == ST_RUN) & ~rs_s & ~ot_now;
         alarm_out   <= alarm & ~rs_s;
         trip_code   <= (alarm && ot_trip_q && !rs_s) ? `TRC_OTEMP_CODE : 8'h00;
         if (rs_rise) begin
            hold_cnt_q <= HOLD_MS;
         end else if (tick_q && hold_cnt_q != 16'h0000) begin
            hold_cnt_q <= hold_cnt_q - 16'h0001;
         end
         if (!rs_s) begin
            logic_out <= logic_out_req;
         end else begin
            logic_out <= logic_out & delay_en_q & {NOUT{hold_cnt_q != 16'h0000 || rs_rise}};
         end
      end
   end
   // ***********************************************
   // AHB-Lite slave
   // ***********************************************
   wire [3:0] ev = {ot_now & (state_q == ST_RUN), remote_link_error_message,
                    do_rst | ((state_q == ST_POR) & ~rs_s),
                    (state_q == ST_RUN) & ot_now};
   wire wr = ap_valid_q & ap_write_q;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid_q <= 1'b0;
         ap_write_q <= 1'b0;
         ap_addr_q  <= 12'h000;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         hrdata     <= 32'h00000000;
         ctrl_q     <= `TRC_CTRL_RST_VAL;
         func_q     <= {NIN{`TRC_FUNC_RST_VAL}};
         delay_en_q <= {NOUT{1'b0}};
         istat_q    <= 4'h0;
         imask_q    <= 4'h0;
         irq        <= 1'b0;
      end else begin
         ap_valid_q <= hsel & hready & htrans[1];
         ap_write_q <= hwrite;
         ap_addr_q  <= haddr[11:0];
         hrdata     <= 32'h00000000;
         if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr[11:0])
               `TRC_OFS_CTRL:     hrdata <= {29'h00000000, ctrl_q};
               `TRC_OFS_STATUS:   hrdata <= {16'h0000, trip_code, 2'h0, rs_s, ot_now,
                                             motor_drive, state_q};
               `TRC_OFS_IRQ_STAT: hrdata <= {28'h0000000, istat_q};
               `TRC_OFS_IRQ_MASK: hrdata <= {28'h0000000, imask_q};
               `TRC_OFS_FUNC:     hrdata <= {func_q[8*NIN-1 -: 8], func_q[23:0]};
               `TRC_OFS_DELAY:    hrdata <= {{(32-NOUT){1'b0}}, delay_en_q};
               default:           hrdata <= 32'h00000000;
            endcase
         end
         if (wr && ap_addr_q == `TRC_OFS_CTRL) begin
            ctrl_q <= hwdata[2:0];
         end
         if (wr && ap_addr_q == `TRC_OFS_FUNC) begin
            // Top byte selects the fifth terminal, fourth terminal unused
            func_q <= {hwdata[31:24], 8'h00, hwdata[23:0]};
         end
         if (wr && ap_addr_q == `TRC_OFS_DELAY) begin
            delay_en_q <= hwdata[NOUT-1:0];
         end
         if (wr && ap_addr_q == `TRC_OFS_IRQ_MASK) begin
            imask_q <= hwdata[3:0];
         end
         if (wr && ap_addr_q == `TRC_OFS_IRQ_STAT) begin
            istat_q <= (istat_q & ~hwdata[3:0]) | ev;
         end else begin
            istat_q <= istat_q | ev;
         end
         irq <= |(istat_q & imask_q);
      end
   end
endmodule
`default_nettype wire

/* bench/trc_far.sv */
`default_nettype none
// ***********************************
// Contacts, thermistor and keypad
// ***********************************
module trc_far #(
   parameter int RS_CYC = 240
) (
   input  wire logic       hclk,
   input  wire logic       rs_go,
   input  wire logic       hot,
   input  wire logic       open_c,
   input  wire logic       key_go,
   output logic            rs_busy,
   output logic [4:0]      term_in,
   output logic            overtemp_open_in,
   output logic            key_stop_reset,
   output logic            key_any
);
   int rs_cnt = 0;
   int key_cnt = 0;
   always @(posedge hclk) begin
      rs_cnt <= rs_go ? RS_CYC : (rs_cnt > 0 ? rs_cnt - 1 : 0);
      key_cnt <= key_go ? 4 : (key_cnt > 0 ? key_cnt - 1 : 0);
   end
   assign rs_busy = rs_cnt > 0;
   // Sensor only on the fifth terminal, idle terminals pulled low
   assign term_in = {hot, 3'b000, rs_busy};
   assign overtemp_open_in = open_c;
   assign key_stop_reset = key_cnt > 0;
   assign key_any = key_cnt > 0;
endmodule
`default_nettype wire

/* bench/trc_chk.sv */
`default_nettype none
// ***********************************
// Port checker
// ***********************************
module trc_chk #(
   parameter NIN  = 5,
   parameter NOUT = 3
) (
   input wire logic            hclk,
   input wire logic            hresetn,
   input wire logic            hsel,
   input wire logic [31:0]     haddr,
   input wire logic [1:0]      htrans,
   input wire logic            hwrite,
   input wire logic [31:0]     hwdata,
   input wire logic            hready,
   input wire logic [NIN-1:0]  term_in,
   input wire logic            overtemp_open_in,
   input wire logic [NOUT-1:0] logic_out,
   input wire logic            motor_drive,
   input wire logic            alarm_out,
   input wire logic [7:0]      trip_code,
   input wire logic            irq
);
   logic [3:0]  wa_q;
   logic [31:0] sh_q [0:7];
   logic        rs_on;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Shadow of written registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wa_q <= 4'h0;
         for (int i = 0; i < 8; i++) sh_q[i] <= 32'h0;
      end else begin
         wa_q <= {hsel & hready & htrans[1] & hwrite, haddr[4:2]};
         if (wa_q[3]) sh_q[wa_q[2:0]] <= hwdata;
      end
   end
   assign rs_on = term_in[0] && sh_q[4][7:0] == 8'h12 && !sh_q[0][2];
   sequence s_rs_start;
      $rose(rs_on);
   endsequence
   sequence s_rs_held;
      rs_on [*4];
   endsequence
   a_alarm_clears: assert property (s_rs_start |-> ##[1:600] !alarm_out)
      else $error("alarm still set after reset");
   a_rs_coast: assert property (s_rs_held |-> !motor_drive)
      else $error("motor driven under reset");
   a_out_drop: assert property ((rs_on && !sh_q[5][0]) [*4] |-> !logic_out[0])
      else $error("output not dropped");
   a_out_hold: assert property (s_rs_start and (sh_q[5][0] && logic_out[0]) |->
      logic_out[0] [*8])
      else $error("delayed output dropped early");
   a_trip_nodrive: assert property ($past(alarm_out) && alarm_out |-> !motor_drive)
      else $error("motor driven in trip");
   a_code_trip: assert property (trip_code != 8'h00 |-> trip_code == 8'h23 && alarm_out)
      else $error("bad trip code");
   a_open_trip: assert property ($rose(overtemp_open_in) && !rs_on &&
      sh_q[4][31:24] == 8'h13 |-> ##[1:6] alarm_out)
      else $error("open sensor no trip");
   a_irq_masked: assert property ((sh_q[3] == 32'h0) [*3] |-> !irq)
      else $error("masked interrupt raised");
   a_run_resume: assert property ($fell(rs_on) && sh_q[0][0] && !overtemp_open_in &&
      !term_in[4] |-> ##[1:8] motor_drive)
      else $error("run not resumed");
endmodule
`default_nettype wire

/* bench/trc_tb_top.sv */
`default_nettype none
module trc_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ***********************************
   // Bench
   // ***********************************
   localparam logic [31:0] A_CTRL = 32'h00, A_IRQ = 32'h08, A_MSK = 32'h0C;
   localparam logic [31:0] A_FUNC = 32'h10, A_DLY = 32'h14;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
   logic        rs_go = 1'b0, hot = 1'b0, open_c = 1'b0, key_go = 1'b0, rs_busy;
   logic        overtemp_open_in, key_stop_reset, key_any, link_err, irq;
   logic        hresp, hreadyout, motor_drive, alarm_out;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2, logic_out_req = 3'h7, logic_out;
   logic [4:0]  term_in;
   logic [7:0]  trip_code;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   wire logic   hready;
   int          fails = 0, n_checks = 0, cyc = 0;
   assign hready = hreadyout;
   trc_far far_u (.hclk(hclk), .rs_go(rs_go), .hot(hot), .open_c(open_c), .key_go(key_go),
      .rs_busy(rs_busy), .term_in(term_in), .overtemp_open_in(overtemp_open_in),
      .key_stop_reset(key_stop_reset), .key_any(key_any));
   trc_top #(.MS_CYC(20), .LINKERR_MS(40), .HOLD_MS(5), .KEY_WIN_MS(30)) dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .term_in(term_in),
      .overtemp_open_in(overtemp_open_in), .key_stop_reset(key_stop_reset),
      .key_any(key_any), .logic_out_req(logic_out_req), .motor_drive(motor_drive),
      .logic_out(logic_out), .alarm_out(alarm_out), .trip_code(trip_code),
      .remote_link_error_message(link_err), .irq(irq));
   initial begin
      forever #25 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [31:0] a, e);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask
   task automatic pulse_rs;
      rs_go <= 1'b1;
      @(posedge hclk);
      rs_go <= 1'b0;
   endtask
   task automatic press_key;
      key_go <= 1'b1;
      @(posedge hclk);
      key_go <= 1'b0;
      repeat (8) @(posedge hclk);
   endtask
   task automatic rs_done;
      while (rs_busy) @(posedge hclk);
      repeat (8) @(posedge hclk);
   endtask
   task automatic t_setup;
      rd(A_IRQ, 32'h2);
      rd(32'h40, 32'h0);
      wr(A_IRQ, 32'hF);
      wr(A_FUNC, 32'h1300_0012);
      wr(A_MSK, 32'hF);
      wr(A_CTRL, 32'h1);
      repeat (8) @(posedge hclk);
      chk(32'({motor_drive, logic_out}), 32'hF);
      chk(32'(link_err), 32'h0);
   endtask
   task automatic t_run_reset;
      pulse_rs();
      repeat (8) @(posedge hclk);
      chk(32'({motor_drive, logic_out}), 32'h0);
      rs_done();
      chk(32'({motor_drive, irq}), 32'h3);
      rd(A_IRQ, 32'h2);
      wr(A_IRQ, 32'h2);
   endtask
   task automatic t_open;
      open_c <= 1'b1;
      repeat (8) @(posedge hclk);
      chk(32'({alarm_out, motor_drive}), 32'h2);
      open_c <= 1'b0;
      pulse_rs();
      repeat (20) @(posedge hclk);
      chk(32'(alarm_out), 32'h0);
      rs_done();
      wr(A_IRQ, 32'hF);
   endtask
   task automatic t_delay;
      wr(A_DLY, 32'h1);
      pulse_rs();
      repeat (60) @(posedge hclk);
      chk(32'(logic_out), 32'h1);
      repeat (90) @(posedge hclk);
      chk(32'(logic_out), 32'h0);
      rs_done();
      wr(A_DLY, 32'h0);
      wr(A_IRQ, 32'hF);
   endtask
   task automatic t_nc;
      wr(A_CTRL, 32'h5);
      pulse_rs();
      repeat (8) @(posedge hclk);
      chk(32'(motor_drive), 32'h1);
      rs_done();
      wr(A_CTRL, 32'h1);
      press_key();
      rd(A_IRQ, 32'h0);
   endtask
   task automatic t_otemp;
      hot <= 1'b1;
      repeat (8) @(posedge hclk);
      chk(32'({alarm_out, motor_drive, irq, trip_code}), 32'h523);
      press_key();
      chk(32'(alarm_out), 32'h1);
      hot <= 1'b0;
      wr(A_CTRL, 32'h3);
      press_key();
      chk(32'(alarm_out), 32'h1);
      wr(A_CTRL, 32'h1);
      press_key();
      chk(32'({alarm_out, motor_drive}), 32'h1);
      rd(A_IRQ, 32'hB);
      wr(A_IRQ, 32'hF);
      repeat (2) @(posedge hclk);
      chk(32'(irq), 32'h0);
   endtask
   task automatic stop_test;
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_setup();
      t_run_reset();
      t_open();
      t_delay();
      t_nc();
      t_otemp();
      stop_test();
   end
endmodule
bind trc_top trc_chk #(.NIN(NIN), .NOUT(NOUT)) chk_u (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
   .hready(hready), .term_in(term_in), .overtemp_open_in(overtemp_open_in),
   .logic_out(logic_out), .motor_drive(motor_drive), .alarm_out(alarm_out),
   .trip_code(trip_code), .irq(irq));
`default_nettype wire
